// ==== hw/dpb_pkg.sv ====
// drive parameter bank: offsets, slots, ranges, reset values, timing
// assumes a 125 MHz pclk; offsets are word indices, byte address = 4 * index
package dpb_pkg;
	localparam int NUM_REGS = 31;
	localparam logic [7:0] OFF_BOOST_M1      = 8'h4F;
	localparam logic [7:0] OFF_BOOST_M2      = 8'h50;
	localparam logic [7:0] OFF_BREAKPT_M1    = 8'h51;
	localparam logic [7:0] OFF_BREAKPT_M2    = 8'h52;
	localparam logic [7:0] OFF_CURVE_M1      = 8'h53;
	localparam logic [7:0] OFF_CURVE_M2      = 8'h54;
	localparam logic [7:0] OFF_VOLT_GAIN     = 8'h55;
	localparam logic [7:0] OFF_DCB_ENABLE    = 8'h5C;
	localparam logic [7:0] OFF_DCB_FREQ      = 8'h5D;
	localparam logic [7:0] OFF_DCB_WAIT      = 8'h5E;
	localparam logic [7:0] OFF_DCB_FORCE     = 8'h5F;
	localparam logic [7:0] OFF_DCB_TIME      = 8'h60;
	localparam logic [7:0] OFF_BRK_DETECT    = 8'h61;
	localparam logic [7:0] OFF_UPPER_M1      = 8'h62;
	localparam logic [7:0] OFF_UPPER_M2      = 8'h63;
	localparam logic [7:0] OFF_LOWER_M1      = 8'h64;
	localparam logic [7:0] OFF_LOWER_M2      = 8'h65;
	localparam logic [7:0] OFF_JUMP_C1       = 8'h66;
	localparam logic [7:0] OFF_JUMP_W1       = 8'h67;
	localparam logic [7:0] OFF_JUMP_C2       = 8'h68;
	localparam logic [7:0] OFF_JUMP_W2       = 8'h69;
	localparam logic [7:0] OFF_JUMP_C3       = 8'h6A;
	localparam logic [7:0] OFF_JUMP_W3       = 8'h6B;
	localparam logic [7:0] OFF_PID_ENABLE    = 8'h6C;
	localparam logic [7:0] OFF_PID_PGAIN     = 8'h6D;
	localparam logic [7:0] OFF_PID_ITIME     = 8'h6E;
	localparam logic [7:0] OFF_PID_DTIME     = 8'h6F;
	localparam logic [7:0] OFF_PV_SCALE      = 8'h70;
	localparam logic [7:0] OFF_PV_SOURCE     = 8'h71;
	localparam logic [7:0] OFF_PID_REVERSE   = 8'hE1;
	localparam logic [7:0] OFF_PID_OUT_LIMIT = 8'hE2;

	typedef enum logic [4:0] {
		S_BOOST_M1, S_BOOST_M2, S_BREAKPT_M1, S_BREAKPT_M2,
		S_CURVE_M1, S_CURVE_M2, S_VOLT_GAIN, S_DCB_ENABLE,
		S_DCB_FREQ, S_DCB_WAIT, S_DCB_FORCE, S_DCB_TIME,
		S_BRK_DETECT, S_UPPER_M1, S_UPPER_M2, S_LOWER_M1,
		S_LOWER_M2, S_JUMP_C1, S_JUMP_W1, S_JUMP_C2,
		S_JUMP_W2, S_JUMP_C3, S_JUMP_W3, S_PID_ENABLE,
		S_PID_PGAIN, S_PID_ITIME, S_PID_DTIME, S_PV_SCALE,
		S_PV_SOURCE, S_PID_REVERSE, S_PID_OUT_LIMIT
	} dpb_slot_t;

	// indexed by slot, same order as dpb_slot_t
	localparam logic [7:0] REG_OFFSET [NUM_REGS] = '{
		OFF_BOOST_M1, OFF_BOOST_M2, OFF_BREAKPT_M1, OFF_BREAKPT_M2,
		OFF_CURVE_M1, OFF_CURVE_M2, OFF_VOLT_GAIN, OFF_DCB_ENABLE,
		OFF_DCB_FREQ, OFF_DCB_WAIT, OFF_DCB_FORCE, OFF_DCB_TIME,
		OFF_BRK_DETECT, OFF_UPPER_M1, OFF_UPPER_M2, OFF_LOWER_M1,
		OFF_LOWER_M2, OFF_JUMP_C1, OFF_JUMP_W1, OFF_JUMP_C2,
		OFF_JUMP_W2, OFF_JUMP_C3, OFF_JUMP_W3, OFF_PID_ENABLE,
		OFF_PID_PGAIN, OFF_PID_ITIME, OFF_PID_DTIME, OFF_PV_SCALE,
		OFF_PV_SOURCE, OFF_PID_REVERSE, OFF_PID_OUT_LIMIT
	};

	localparam logic [15:0] BOOST_MAX      = 16'h00C8;
	localparam logic [15:0] BREAKPT_MAX    = 16'h01F4;
	localparam logic [15:0] CODE_BIN_MAX   = 16'h0001;
	localparam logic [15:0] GAIN_MIN       = 16'h0014;
	localparam logic [15:0] PCT_MAX        = 16'h0064;
	localparam logic [15:0] DCB_FREQ_MAX   = 16'h0258;
	localparam logic [15:0] DCB_WAIT_MAX   = 16'h0032;
	localparam logic [15:0] DCB_TIME_MAX   = 16'h0258;
	localparam logic [15:0] JUMP_C_MAX     = 16'h0FA0;
	localparam logic [15:0] JUMP_W_MAX     = 16'h0064;
	localparam logic [15:0] PGAIN_MIN      = 16'h0002;
	localparam logic [15:0] PGAIN_MAX      = 16'h0032;
	localparam logic [15:0] ITIME_MAX      = 16'h05DC;
	localparam logic [15:0] DTIME_MAX      = 16'h03E8;
	localparam logic [15:0] SCALE_MIN      = 16'h0001;
	localparam logic [15:0] SCALE_MAX      = 16'h270F;
	localparam logic [15:0] PV_SRC_MAX     = 16'h0003;
	localparam logic [15:0] PID_LIM_MAX    = 16'h03E8;
	localparam logic [15:0] FREQ_SCALE     = 16'h000A;

	localparam logic [1:0] PV_SRC_CURRENT  = 2'h0;
	localparam logic [1:0] PV_SRC_VOLTAGE  = 2'h1;
	localparam logic [1:0] PV_SRC_NETWORK  = 2'h2;
	localparam logic [1:0] PV_SRC_CALC     = 2'h3;

	localparam logic [15:0] RST_VOLT_GAIN  = 16'h0064;
	localparam logic [15:0] RST_PID_PGAIN  = 16'h000A;
	localparam logic [15:0] RST_PV_SCALE   = 16'h0064;
	localparam logic [15:0] RST_DCB_FREQ   = 16'h0005;

	localparam int CLK_HZ          = 125_000_000;
	localparam int TICK_TIME_MS    = 100;
	localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_TIME_MS;

	typedef enum logic [1:0] {BRK_IDLE, BRK_WAIT, BRK_ON} dpb_brake_t;
endpackage

// ==== hw/dpb_bank.sv ====
// drive parameter bank: APB register file with range checks, option
// decode, dc brake sequencer, limit/jump frequency shaping and pid glue.
// assumes an APB master on pclk and synchronous side inputs.
`timescale 1ns/1ns
module dpb_bank
	import dpb_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int          VALUE_W     = 16
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	input  wire logic [9:0]          start_frequency_setting,
	input  wire logic [9:0]          maximum_frequency_setting,
	input  wire logic                motor2_select,
	input  wire logic                decel_done,
	input  wire logic                brake_request_input,
	input  wire logic [15:0]         freq_command,
	input  wire logic [15:0]         current_input_terminal,
	input  wire logic [15:0]         voltage_input_terminal,
	input  wire logic [15:0]         network_pv,
	input  wire logic [15:0]         calc_output,
	input  wire logic [15:0]         setpoint_value,
	input  wire logic signed [15:0]  pid_raw,
	output logic [15:0]              boost_value,
	output logic [15:0]              boost_breakpoint,
	output logic                     reduced_torque,
	output logic [15:0]              freq_out,
	output logic                     brake_active,
	output logic [15:0]              brake_force,
	output logic                     pid_enabled,
	output logic [15:0]              process_variable,
	output logic signed [16:0]       pid_error,
	output logic signed [15:0]       pid_out
);
	// the state struct and the range constants are fixed at 16 bits
	if (VALUE_W != 16 || TICK_CYCLES < 1) begin
		$error("dpb_bank: unsupported parameter values");
	end

	typedef struct packed {
		logic [NUM_REGS-1:0][15:0] regs;
		logic                      pready;
		logic [31:0]               prdata;
		logic                      pslverr;
		logic                      wr_ok;
		dpb_brake_t                brk;
		logic [31:0]               tick_cnt;
		logic [15:0]               tenth_cnt;
		logic                      brk_in_d;
		logic                      brake_active;
		logic [15:0]               brake_force;
		logic [15:0]               boost_value;
		logic [15:0]               boost_breakpoint;
		logic                      reduced_torque;
		logic [15:0]               freq_out;
		logic                      pid_enabled;
		logic [15:0]               process_variable;
		logic signed [16:0]        pid_error;
		logic signed [15:0]        pid_out;
	} dpb_state_t;

	dpb_state_t s;
	dpb_state_t next_s;

	function automatic logic [15:0] rst_value(int i);
		unique case (i)
			int'(S_VOLT_GAIN): return RST_VOLT_GAIN;
			int'(S_PID_PGAIN): return RST_PID_PGAIN;
			int'(S_PV_SCALE):  return RST_PV_SCALE;
			int'(S_DCB_FREQ):  return RST_DCB_FREQ;
			default:           return 16'h0000;
		endcase
	endfunction

	function automatic dpb_state_t reset_state();
		dpb_state_t r;
		r = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			r.regs[i] = rst_value(i);
		end
		r.brk = BRK_IDLE;
		return r;
	endfunction

	function automatic logic in_rng(logic [15:0] v, logic [15:0] lo,
			logic [15:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	// cross-checks read the other limit as it stands now; a pair is
	// reprogrammed by clearing one side to zero first
	function automatic logic value_ok(dpb_slot_t sl, logic [15:0] v,
			logic [NUM_REGS-1:0][15:0] r, logic [15:0] st10,
			logic [15:0] mx10);
		logic [15:0] up;
		logic [15:0] lo;
		up = 16'h0000;
		lo = 16'h0000;
		unique case (sl)
			S_BOOST_M1, S_BOOST_M2:     return v <= BOOST_MAX;
			S_BREAKPT_M1, S_BREAKPT_M2: return v <= BREAKPT_MAX;
			S_CURVE_M1, S_CURVE_M2:     return v <= CODE_BIN_MAX;
			S_VOLT_GAIN:  return in_rng(v, GAIN_MIN, PCT_MAX);
			S_DCB_ENABLE: return v <= CODE_BIN_MAX;
			S_DCB_FREQ:   return in_rng(v, st10, DCB_FREQ_MAX);
			S_DCB_WAIT:   return v <= DCB_WAIT_MAX;
			S_DCB_FORCE:  return v <= PCT_MAX;
			S_DCB_TIME:   return v <= DCB_TIME_MAX;
			S_BRK_DETECT: return v <= CODE_BIN_MAX;
			S_UPPER_M1, S_UPPER_M2: begin
				lo = (sl == S_UPPER_M1) ? r[S_LOWER_M1] : r[S_LOWER_M2];
				return (v == 16'h0000) || in_rng(v, lo, mx10);
			end
			S_LOWER_M1, S_LOWER_M2: begin
				up = (sl == S_LOWER_M1) ? r[S_UPPER_M1] : r[S_UPPER_M2];
				if (up == 16'h0000)
					up = mx10;
				return (v == 16'h0000) || in_rng(v, st10, up);
			end
			S_JUMP_C1, S_JUMP_C2, S_JUMP_C3: return v <= JUMP_C_MAX;
			S_JUMP_W1, S_JUMP_W2, S_JUMP_W3: return v <= JUMP_W_MAX;
			S_PID_ENABLE:  return v <= CODE_BIN_MAX;
			S_PID_PGAIN:   return in_rng(v, PGAIN_MIN, PGAIN_MAX);
			S_PID_ITIME:   return v <= ITIME_MAX;
			S_PID_DTIME:   return v <= DTIME_MAX;
			S_PV_SCALE:    return in_rng(v, SCALE_MIN, SCALE_MAX);
			S_PV_SOURCE:   return v <= PV_SRC_MAX;
			S_PID_REVERSE: return v <= CODE_BIN_MAX;
			S_PID_OUT_LIMIT: return v <= PID_LIM_MAX;
			default:       return 1'b0;
		endcase
	endfunction

	logic        hit;
	dpb_slot_t   slot;
	logic [15:0] cur;
	logic [15:0] wval;
	logic [15:0] st10;
	logic [15:0] mx10;
	logic        tick;
	logic        brk_edge;
	logic [16:0] f;
	logic [16:0] c;
	logic [16:0] w;
	logic [15:0] up_lim;
	logic [15:0] lo_lim;
	logic signed [16:0] lim;

	// address decode against the offset table
	// only the lowest kilobyte decodes; anything above answers with an error
	always_comb begin
		hit  = 1'b0;
		slot = S_BOOST_M1;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (paddr[11:10] == 2'h0 && paddr[9:2] == REG_OFFSET[i]) begin
				hit  = 1'b1;
				slot = dpb_slot_t'(i);
			end
		end
		cur  = s.regs[slot];
		// upper strobes are ignored: each register is one 16-bit half word
		wval = {pstrb[1] ? pwdata[15:8] : cur[15:8],
			pstrb[0] ? pwdata[7:0] : cur[7:0]};
		// start and maximum inputs are whole Hz, registers hold 0.1 Hz
		st10 = 16'(16'(start_frequency_setting) * FREQ_SCALE);
		mx10 = 16'(16'(maximum_frequency_setting) * FREQ_SCALE);
	end

	always_comb begin
		next_s = s;
		tick   = 1'b0;
		c      = 17'h0;
		w      = 17'h0;
		brk_edge = brake_request_input && !s.brk_in_d;

		// apb: setup cycle prepares the answer, first access cycle ends it
		// error only qualifies the answer cycle; read data stays until
		// the next setup
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (psel && !penable && !s.pready) begin
			next_s.pready  = 1'b1;
			next_s.prdata  = (hit && !pwrite) ? {16'h0000, cur} : 32'h0;
			next_s.wr_ok   = hit && value_ok(slot, wval, s.regs, st10, mx10);
			next_s.pslverr = !hit || (pwrite && !next_s.wr_ok);
		end
		// a refused write never reaches the register, the old value stays
		if (psel && penable && s.pready && pwrite && s.wr_ok)
			next_s.regs[slot] = wval;

		// dc brake sequencer, time base in 0.1 s ticks
		// the tick counter only runs outside idle (wait and braking), so it restarts per event
		next_s.brk_in_d = brake_request_input;
		if (s.brk != BRK_IDLE) begin
			if (s.tick_cnt == 32'(TICK_CYCLES - 1)) begin
				next_s.tick_cnt = 32'h0;
				tick = 1'b1;
			end else begin
				next_s.tick_cnt = s.tick_cnt + 32'h1;
			end
		end
		unique case (s.brk)
			BRK_IDLE: begin
				next_s.tick_cnt  = 32'h0;
				next_s.tenth_cnt = 16'h0;
				if (s.regs[S_BRK_DETECT][0] == 1'b0 && brk_edge)
					next_s.brk = BRK_ON;
				else if (decel_done && s.regs[S_DCB_ENABLE][0])
					next_s.brk = (s.regs[S_DCB_WAIT] == 16'h0) ?
						BRK_ON : BRK_WAIT;
			end
			BRK_WAIT: begin
				// motor free runs here
				if (tick) begin
					next_s.tenth_cnt = s.tenth_cnt + 16'h1;
					if (s.tenth_cnt + 16'h1 >= s.regs[S_DCB_WAIT]) begin
						next_s.brk       = BRK_ON;
						next_s.tenth_cnt = 16'h0;
					end
				end
			end
			BRK_ON: begin
				// a new request while braking does not restart the timer
				if (s.tenth_cnt >= s.regs[S_DCB_TIME]) begin
					next_s.brk = BRK_IDLE;
				end else if (tick) begin
					next_s.tenth_cnt = s.tenth_cnt + 16'h1;
				end
			end
			// code 3 is never entered; an upset returns to idle
			default: next_s.brk = BRK_IDLE;
		endcase
		// level mode follows the input directly while it is high
		next_s.brake_active = (next_s.brk == BRK_ON) ||
			(s.regs[S_BRK_DETECT][0] && brake_request_input);
		next_s.brake_force = next_s.brake_active ?
			s.regs[S_DCB_FORCE] : 16'h0;

		// per motor selection
		next_s.boost_value = motor2_select ? s.regs[S_BOOST_M2] :
			s.regs[S_BOOST_M1];
		next_s.boost_breakpoint = motor2_select ? s.regs[S_BREAKPT_M2] :
			s.regs[S_BREAKPT_M1];
		next_s.reduced_torque = motor2_select ? s.regs[S_CURVE_M2][0] :
			s.regs[S_CURVE_M1][0];
		// limits follow the selected motor in the same cycle as the command
		up_lim = motor2_select ? s.regs[S_UPPER_M2] : s.regs[S_UPPER_M1];
		lo_lim = motor2_select ? s.regs[S_LOWER_M2] : s.regs[S_LOWER_M1];

		// limit, then skip the jump bands
		f = {1'b0, freq_command};
		if (up_lim != 16'h0 && f > {1'b0, up_lim})
			f = {1'b0, up_lim};
		if (lo_lim != 16'h0 && f < {1'b0, lo_lim})
			f = {1'b0, lo_lim};
		// bands apply in order, so a later band can move a value pushed out of an earlier one up or down
		for (int k = 0; k < 3; k++) begin
			c = {1'b0, s.regs[int'(S_JUMP_C1) + 2 * k]};
			w = {1'b0, s.regs[int'(S_JUMP_W1) + 2 * k]};
			if (c != 17'h0 && w != 17'h0 && f + w >= c && f <= c + w)
				f = (f < c && c >= w) ? c - w : c + w;
		end
		next_s.freq_out = f[16] ? 16'hFFFF : f[15:0];

		// pid glue
		next_s.pid_enabled = s.regs[S_PID_ENABLE][0];
		unique case (s.regs[S_PV_SOURCE][1:0])
			PV_SRC_CURRENT: next_s.process_variable = current_input_terminal;
			PV_SRC_VOLTAGE: next_s.process_variable = voltage_input_terminal;
			PV_SRC_NETWORK: next_s.process_variable = network_pv;
			PV_SRC_CALC:    next_s.process_variable = calc_output;
		endcase
		// pv is registered first, so the error lags its source by two cycles
		next_s.pid_error = $signed({1'b0, setpoint_value}) -
			$signed({1'b0, s.process_variable});
		if (s.regs[S_PID_REVERSE][0])
			next_s.pid_error = -next_s.pid_error;
		// a zero limit pins the output at zero
		lim = $signed({1'b0, s.regs[S_PID_OUT_LIMIT]});
		if (17'(pid_raw) > lim)
			next_s.pid_out = 16'(lim);
		else if (17'(pid_raw) < -lim)
			next_s.pid_out = 16'(-lim);
		else
			next_s.pid_out = pid_raw;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s <= reset_state();
		else
			s <= next_s;
	end

	assign pready           = s.pready;
	assign prdata           = s.prdata;
	assign pslverr          = s.pslverr;
	assign boost_value      = s.boost_value;
	assign boost_breakpoint = s.boost_breakpoint;
	assign reduced_torque   = s.reduced_torque;
	assign freq_out         = s.freq_out;
	assign brake_active     = s.brake_active;
	assign brake_force      = s.brake_force;
	assign pid_enabled      = s.pid_enabled;
	assign process_variable = s.process_variable;
	assign pid_error        = s.pid_error;
	assign pid_out          = s.pid_out;
endmodule

// ==== sim/dpb_host.sv ====
// host model: apb master that reads and writes the parameter bank
// assumes pclk from the bench and a slave that answers with pready
`timescale 1ns/1ns
module dpb_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb
);
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end

	// an idle cycle between transfers; request held until pready is seen,
	// only the bench timeout ends a wait that never completes
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [15:0] d, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
endmodule

// ==== sim/dpb_bank_chk.sv ====
// checker for the parameter bank: apb handshake, refusals, pid and brake
// assumes it is bound to dpb_bank and sees only its ports
`timescale 1ns/1ns
module dpb_bank_chk
	import dpb_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic [11:0]        paddr,
	input wire logic               pready,
	input wire logic [31:0]        prdata,
	input wire logic               pslverr,
	input wire logic [15:0]        setpoint_value,
	input wire logic [15:0]        process_variable,
	input wire logic signed [16:0] pid_error,
	input wire logic signed [15:0] pid_raw,
	input wire logic signed [15:0] pid_out,
	input wire logic               brake_active,
	input wire logic [15:0]        brake_force
);
	logic [1:0]         up;
	logic signed [16:0] dif;

	function automatic logic mapped(logic [11:0] a);
		mapped = 1'h0;
		for (int i = 0; i < NUM_REGS; i++)
			if (a[11:10] == 2'h0 && a[9:2] == REG_OFFSET[i])
				mapped = 1'h1;
	endfunction

	// outputs lag one or two cycles, so data relations wait for both
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up <= 2'h0;
			dif <= 17'h0;
		end else begin
			up <= {up[0], 1'h1};
			dif <= $signed({1'h0, setpoint_value})
				- $signed({1'h0, process_variable});
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable && !pready;
	endsequence
	sequence s_bad_setup;
		s_setup ##0 !mapped(paddr);
	endsequence

	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("no answer one cycle after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_unmapped_err: assert property (
		s_bad_setup |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_upper: assert property (pready |-> prdata[31:16] == 16'h0)
		else $error("read data upper half not zero");
	a_force_idle: assert property (!brake_active |-> brake_force == 16'h0)
		else $error("brake force while brake idle");
	a_pid_err_diff: assert property (up[1] |->
		pid_error == dif || pid_error == -dif)
		else $error("pid error not setpoint minus pv");
	a_pid_out_clamp: assert property (up[1] |-> ($past(pid_raw) >= 0) ?
		(pid_out >= 0 && pid_out <= $past(pid_raw)) :
		(pid_out <= 0 && pid_out >= $past(pid_raw)))
		else $error("pid output not a clamp of its input");
endmodule

// ==== sim/test_drive_parameter_bank_a42_a78.sv ====
// bench for the parameter bank: reset values, range refusals, limits,
// jump bands, pid glue and brake sequencing through the host model
// assumes dpb_host as apb master and a four-cycle brake tick
`timescale 1ns/1ns
module test_drive_parameter_bank_a42_a78;
	import dpb_pkg::*;
	localparam int unsigned TICK_CYCLES = 4;
	localparam int NT = 21;
	localparam dpb_slot_t TS [NT] = '{S_BOOST_M1, S_BREAKPT_M2, S_CURVE_M1,
		S_VOLT_GAIN, S_DCB_ENABLE, S_DCB_FREQ, S_DCB_WAIT, S_DCB_FORCE,
		S_DCB_TIME, S_BRK_DETECT, S_JUMP_C2, S_JUMP_W3, S_PID_ENABLE,
		S_PID_PGAIN, S_PID_ITIME, S_PID_DTIME, S_PV_SCALE, S_PV_SOURCE,
		S_PID_REVERSE, S_PID_OUT_LIMIT, S_BREAKPT_M1};
	localparam logic [15:0] TL [NT] = '{0, 0, 0, 'h14, 0, 'h32, 0, 0, 0, 0,
		0, 0, 0, 'h2, 0, 0, 'h1, 0, 0, 0, 0};
	localparam logic [15:0] TH [NT] = '{'hC8, 'h1F4, 'h1, 'h64, 'h1, 'h258,
		'h32, 'h64, 'h258, 'h1, 'hFA0, 'h64, 'h1, 'h32, 'h5DC, 'h3E8,
		'h270F, 'h3, 'h1, 'h3E8, 'h1F4};
	localparam logic signed [15:0] PR [4] = '{'h1F4, 'hFE0C, 'h32, 'h64};
	localparam logic signed [15:0] PE [4] = '{'h64, 'hFF9C, 'h32, 'h64};
	logic                pclk, presetn, psel, penable, pwrite, pready;
	logic                pslverr, motor2_select, decel_done;
	logic                brake_request_input, reduced_torque;
	logic                brake_active, pid_enabled;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata;
	logic [3:0]          pstrb;
	logic [9:0]          start_frequency_setting, maximum_frequency_setting;
	logic [15:0]         freq_command, setpoint_value, boost_value;
	logic [15:0]         boost_breakpoint, freq_out, brake_force;
	logic [15:0]         process_variable, e;
	logic [15:0]         pv [4];
	logic signed [15:0]  pid_raw, pid_out;
	logic signed [16:0]  pid_error;
	logic signed [31:0]  ev;
	logic [31:0]         r;
	logic                x;
	int                  error_cnt, compares, cyc, d, h;

	dpb_bank #(.TICK_CYCLES(TICK_CYCLES)) i_dpb_bank (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
		.pslverr, .start_frequency_setting, .maximum_frequency_setting,
		.motor2_select, .decel_done, .brake_request_input, .freq_command,
		.current_input_terminal(pv[0]), .voltage_input_terminal(pv[1]),
		.network_pv(pv[2]), .calc_output(pv[3]), .setpoint_value, .pid_raw,
		.boost_value, .boost_breakpoint, .reduced_torque, .freq_out,
		.brake_active, .brake_force, .pid_enabled, .process_variable,
		.pid_error, .pid_out);
	dpb_host host (.pclk, .pready, .prdata, .pslverr, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb);

	initial pclk = 1'h0;
	always #4 pclk = ~pclk;
	// far above the less than one thousand cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rng(input int v, input int lo, input int hi);
		compares++;
		if (v < lo || v > hi) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h..%h", $time, v, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [15:0] v, input logic f);
		host.xfer(1'h1, idx, v, r, x);
		chk({31'h0, x}, {31'h0, f});
	endtask
	task automatic rd(input logic [7:0] idx, input logic [15:0] v);
		host.xfer(1'h0, idx, 16'h0, r, x);
		chk({31'h0, x}, 32'h0);
		chk(r, {16'h0, v});
	endtask
	task automatic settle();
		repeat (3) @(posedge pclk);
	endtask
	task automatic fchk(input logic [15:0] c, input logic [15:0] v);
		freq_command <= c;
		settle();
		chk({16'h0, freq_out}, {16'h0, v});
	endtask
	task automatic pulse();
		decel_done <= 1'h1;
		@(posedge pclk);
		decel_done <= 1'h0;
	endtask
	// cycles until braking starts, and how long it lasts (100 = still on)
	task automatic brk();
		d = 0;
		h = 0;
		while (brake_active !== 1'h1 && d < 100) begin
			@(posedge pclk);
			d++;
		end
		if (d < 100)
			chk({16'h0, brake_force}, 32'h64);
		while (brake_active === 1'h1 && h < 100) begin
			@(posedge pclk);
			h++;
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		presetn = 1'h0;
		start_frequency_setting = 10'h005;
		maximum_frequency_setting = 10'h03C;
		{motor2_select, decel_done, brake_request_input} = 3'h0;
		freq_command = 16'h0;
		setpoint_value = 16'h0100;
		pid_raw = 16'h0;
		pv = '{16'h0011, 16'h0022, 16'h0033, 16'h0044};
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < NUM_REGS; i++) begin
			e = (i == S_VOLT_GAIN) ? RST_VOLT_GAIN : (i == S_PID_PGAIN) ?
				RST_PID_PGAIN : (i == S_PV_SCALE) ? RST_PV_SCALE :
				(i == S_DCB_FREQ) ? RST_DCB_FREQ : 16'h0;
			rd(REG_OFFSET[i], e);
		end
		host.xfer(1'h0, 8'h00, 16'h0, r, x);
		chk({31'h0, x}, 32'h1);
		chk(r, 32'h0);
		$display("test reset and map finished");
		for (int i = 0; i < NT; i++) begin
			wr(REG_OFFSET[TS[i]], TH[i], 1'h0);
			wr(REG_OFFSET[TS[i]], TH[i] + 16'h1, 1'h1);
			if (TL[i] != 16'h0)
				wr(REG_OFFSET[TS[i]], TL[i] - 16'h1, 1'h1);
			rd(REG_OFFSET[TS[i]], TH[i]);
		end
		chk({31'h0, pid_enabled}, 32'h1);
		$display("test ranges finished");
		wr(OFF_UPPER_M1, 16'h0259, 1'h1);
		wr(OFF_UPPER_M1, 16'h0190, 1'h0);
		wr(OFF_LOWER_M1, 16'h0031, 1'h1);
		wr(OFF_LOWER_M1, 16'h0191, 1'h1);
		wr(OFF_LOWER_M1, 16'h0064, 1'h0);
		wr(OFF_UPPER_M1, 16'h0063, 1'h1);
		wr(OFF_UPPER_M2, 16'h00F0, 1'h0);
		fchk(16'h01F4, 16'h0190);
		fchk(16'h0014, 16'h0064);
		wr(OFF_JUMP_C1, 16'h012C, 1'h0);
		wr(OFF_JUMP_W1, 16'h0014, 1'h0);
		fchk(16'h0122, 16'h0118);
		fchk(16'h012C, 16'h0140);
		fchk(16'h0140, 16'h0140);
		fchk(16'h0141, 16'h0141);
		motor2_select <= 1'h1;
		fchk(16'h01F4, 16'h00F0);
		fchk(16'h0014, 16'h0014);
		wr(OFF_BOOST_M2, 16'h0007, 1'h0);
		settle();
		chk({boost_value, 15'h0, reduced_torque}, 32'h70000);
		motor2_select <= 1'h0;
		settle();
		chk({boost_value, 15'h0, reduced_torque}, 32'hC80001);
		chk({16'h0, boost_breakpoint}, 32'h1F4);
		$display("test limits and jumps finished");
		for (int k = 0; k < 8; k++) begin
			wr(OFF_PID_REVERSE, 16'(k / 4), 1'h0);
			wr(OFF_PV_SOURCE, 16'(k % 4), 1'h0);
			pv[k % 4] <= 16'(k * 16 + 5);
			setpoint_value <= 16'(k * 3 + 16);
			settle();
			chk({16'h0, process_variable}, {16'h0, pv[k % 4]});
			ev = {16'h0, setpoint_value} - {16'h0, pv[k % 4]};
			chk(32'(pid_error), (k / 4 == 1) ? -ev : ev);
		end
		wr(OFF_PID_OUT_LIMIT, 16'h0064, 1'h0);
		for (int k = 0; k < 4; k++) begin
			pid_raw <= PR[k];
			settle();
			chk(32'(pid_out), 32'(PE[k]));
		end
		$display("test pid finished");
		wr(OFF_DCB_TIME, 16'h0003, 1'h0);
		wr(OFF_DCB_WAIT, 16'h0002, 1'h0);
		wr(OFF_DCB_ENABLE, 16'h0000, 1'h0);
		pulse();
		brk();
		rng(d, 100, 100);
		wr(OFF_DCB_ENABLE, 16'h0001, 1'h0);
		pulse();
		brk();
		rng(d, 7, 11);
		rng(h, 11, 14);
		wr(OFF_DCB_WAIT, 16'h0000, 1'h0);
		pulse();
		brk();
		rng(d, 0, 2);
		wr(OFF_BRK_DETECT, 16'h0000, 1'h0);
		brake_request_input <= 1'h1;
		brk();
		rng(d, 0, 2);
		rng(h, 11, 14);
		brake_request_input <= 1'h0;
		wr(OFF_BRK_DETECT, 16'h0001, 1'h0);
		brake_request_input <= 1'h1;
		brk();
		rng(h, 100, 100);
		brake_request_input <= 1'h0;
		settle();
		chk({31'h0, brake_active}, 32'h0);
		$display("test brake finished");
		close_out();
	end
endmodule

bind dpb_bank dpb_bank_chk #(.TICK_CYCLES(TICK_CYCLES)) i_dpb_bank_chk (
	.pclk, .presetn, .psel, .penable, .paddr, .pready, .prdata, .pslverr,
	.setpoint_value, .process_variable, .pid_error, .pid_raw, .pid_out,
	.brake_active, .brake_force);
